// file: include/rmc_pkg.sv
package rmc_pkg;
	// ***********************************************************
	// Register map (byte addresses on the AHB-Lite slave)
	// ***********************************************************
	localparam logic [7:0] RMC_OFS_MODE = 8'h00;
	localparam logic [7:0] RMC_OFS_TCTL = 8'h04;
	localparam logic [7:0] RMC_OFS_TCNT = 8'h08;
	localparam logic [7:0] RMC_OFS_TCON = 8'h0C;
	localparam logic [7:0] RMC_OFS_STAT = 8'h10;

	// ***********************************************************
	// Reset values
	// ***********************************************************
	localparam logic [7:0] RMC_MODE_RST = 8'h02;
	localparam logic [7:0] RMC_TCTL_RST = 8'h07;
	localparam logic [7:0] RMC_TCNT_RST = 8'h00;
	localparam logic [7:0] RMC_TCON_RST = 8'hFF;

	// ***********************************************************
	// Field positions of refresh_mode_control
	// ***********************************************************
	localparam int RMC_B_SELF = 7;
	localparam int RMC_B_PSRAM = 6;
	localparam int RMC_B_DRAM = 5;
	localparam int RMC_B_STROBE = 4;
	localparam int RMC_B_COL = 3;
	localparam int RMC_B_PIN = 2;
	localparam int RMC_B_FIXED = 1;
	localparam int RMC_B_CYC = 0;
	// Bits that stay writable once a memory is connected
	localparam logic [7:0] RMC_MODE_OPEN = 8'hE0;

	// ***********************************************************
	// Field positions of timer_control_status
	// ***********************************************************
	localparam int RMC_B_CMF = 7;
	localparam int RMC_B_CMIE = 6;
	localparam logic [7:0] RMC_TCTL_ONES = 8'h07;

	// Bus and refresh cycle length in system clock states, and the AHB NONSEQ transfer code
	localparam logic [1:0] RMC_AREA3_STATES = 2'd3;
	localparam logic [1:0] RMC_HTRANS_NONSEQ = 2'b10;

	// Memory-type decode
	typedef enum logic [3:0]
	{
		RMC_MEM_TIMER = 4'b0001,
		RMC_MEM_DRAM = 4'b0010,
		RMC_MEM_PSRAM = 4'b0100,
		RMC_MEM_BAD = 4'b1000
	} rmc_mem_e;

	// Standby sequencing
	typedef enum logic [2:0]
	{
		RMC_SB_NORMAL = 3'b001,
		RMC_SB_SELF = 3'b010,
		RMC_SB_RESUME = 3'b100
	} rmc_sb_e;

	// Refresh cycle states
	typedef enum logic [3:0]
	{
		RMC_CY_IDLE = 4'b0001,
		RMC_CY_T1 = 4'b0010,
		RMC_CY_T2 = 4'b0100,
		RMC_CY_T3 = 4'b1000
	} rmc_cyc_e;
endpackage

// file: include/rmc_cyc_if.sv
`timescale 1ns/1ps
// Handshake between the mode logic and the refresh cycle sequencer
interface rmc_cyc_if;
	logic start;
	logic active;
	logic last;
	modport ctl (output start, input active, input last);
	modport seq (input start, output active, output last);
endinterface

// file: logic/rmc_cycle.sv
`timescale 1ns/1ps
// Three-state refresh cycle sequencer for area 3
module rmc_cycle
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	rmc_cyc_if.seq cyc
);
	import rmc_pkg::*;

	rmc_cyc_e state;
	rmc_cyc_e next_state;

	// Next state: a cycle always runs T1, T2, T3 with no waits
	always_comb
	begin
		next_state = state;
		unique case (state)
			RMC_CY_IDLE:
			begin
				if (cyc.start)
					next_state = RMC_CY_T1;
			end
			RMC_CY_T1: next_state = RMC_CY_T2;
			RMC_CY_T2: next_state = RMC_CY_T3;
			RMC_CY_T3: next_state = RMC_CY_IDLE;
			default: next_state = RMC_CY_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			state <= RMC_CY_IDLE;
		else
			state <= next_state;
	end

	assign cyc.active = (state != RMC_CY_IDLE);
	assign cyc.last = (state == RMC_CY_T3);

	// ***********************************************************
	// Assertions
	// ***********************************************************
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_cycle_start;
		cyc.start;
	endsequence
	sequence s_cycle_body;
		cyc.active [*3] ##1 !cyc.active;
	endsequence
	// A cycle never stretches, so the strobe timing stays fixed
	a_cycle_three_states: assert property
		(s_cycle_start |=> s_cycle_body)
		else $error("refresh cycle not three states");
endmodule

// file: logic/rmc_top.sv
`timescale 1ns/1ps
module rmc_top
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic hw_standby_i,
	input wire logic sw_standby_i,
	input wire logic refresh_req_i,
	input wire logic compare_match_i,
	input wire logic area3_access_state_bit_i,
	input wire logic port_data_i,
	input wire logic port_oe_n_i,
	output logic refresh_indicator_pin_o,
	output logic refresh_indicator_pin_oe_n_o,
	output logic area3_three_state_o,
	output logic area3_wait_enable_o,
	output logic refresh_cycle_o,
	output logic dram_mode_o,
	output logic psram_mode_o,
	output logic strobe_two_cas_o,
	output logic column_nine_bit_o,
	output logic self_refresh_o,
	output logic [7:0] timer_clock_select_o
);
	import rmc_pkg::*;

	// ***********************************************************
	// Mode decode
	// ***********************************************************
	function automatic rmc_mem_e decode_mem(input logic [7:0] mode);
		case ({mode[RMC_B_PSRAM], mode[RMC_B_DRAM]})
			2'b00: decode_mem = RMC_MEM_TIMER;
			2'b01: decode_mem = RMC_MEM_DRAM;
			2'b10: decode_mem = RMC_MEM_PSRAM;
			default: decode_mem = RMC_MEM_BAD;
		endcase
	endfunction

	logic [7:0] refresh_mode_control;
	logic [7:0] timer_control_status;
	logic [7:0] interval_counter;
	logic [7:0] interval_constant;
	logic flag_seen;
	rmc_mem_e mem;
	logic mem_on;
	logic mem_ok;
	rmc_sb_e sb_state;
	rmc_sb_e next_sb_state;
	logic dp_valid, dp_write;
	logic [7:0] dp_addr;
	logic wr_mode, wr_tctl, wr_tcnt, wr_tcon;
	logic rd_tctl;
	logic clear_all;
	logic [7:0] next_rdata;
	rmc_cyc_if cyc ();

	// Decoded memory type steers the area 3, DRAM/PSRAM mode and refresh outputs
	assign mem = decode_mem(refresh_mode_control);
	assign mem_on = (mem != RMC_MEM_TIMER);
	// Illegal combination refreshes nothing rather than guessing
	assign mem_ok = (mem == RMC_MEM_DRAM) || (mem == RMC_MEM_PSRAM);
	assign clear_all = rst_i || hw_standby_i;

	// ***********************************************************
	// AHB-Lite slave
	// ***********************************************************
	// Address phase capture; zero-wait slave, always OKAY
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= 8'h00;
		end
		else if (hready_i)
		begin
			dp_valid <= hsel_i && htrans_i[1];
			dp_write <= hwrite_i;
			dp_addr <= haddr_i;
		end
	end

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign wr_mode = dp_valid && dp_write && (dp_addr == RMC_OFS_MODE);
	assign wr_tctl = dp_valid && dp_write && (dp_addr == RMC_OFS_TCTL);
	assign wr_tcnt = dp_valid && dp_write && (dp_addr == RMC_OFS_TCNT);
	assign wr_tcon = dp_valid && dp_write && (dp_addr == RMC_OFS_TCON);
	assign rd_tctl = hready_i && hsel_i && htrans_i[1] && !hwrite_i
		&& (haddr_i == RMC_OFS_TCTL);

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		next_rdata = 8'h00;
		unique case (haddr_i)
			RMC_OFS_MODE: next_rdata = refresh_mode_control;
			RMC_OFS_TCTL: next_rdata = timer_control_status;
			RMC_OFS_TCNT: next_rdata = interval_counter;
			RMC_OFS_TCON: next_rdata = interval_constant;
			RMC_OFS_STAT: next_rdata = {1'b0, sb_state, mem};
			default: next_rdata = 8'h00;
		endcase
	end

	// Read data registered at the address phase edge
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			hrdata_o <= 32'h0000_0000;
		else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i)
			hrdata_o <= {24'h00_0000, next_rdata};
	end

	// ***********************************************************
	// Mode register
	// ***********************************************************
	// Locked fields keep their value once a memory is connected
	always_ff @(posedge ref_clk_i)
	begin
		if (clear_all)
			refresh_mode_control <= RMC_MODE_RST;
		else if (wr_mode)
		begin
			if (mem_on)
				refresh_mode_control <=
					(hwdata_i[7:0] & RMC_MODE_OPEN)
					| (refresh_mode_control & ~RMC_MODE_OPEN);
			else
				refresh_mode_control <= hwdata_i[7:0];
			refresh_mode_control[RMC_B_FIXED] <= 1'b1;
		end
	end

	// ***********************************************************
	// Timer registers (storage and protection only)
	// ***********************************************************
	// The flag may be cleared only after it was read as 1
	always_ff @(posedge ref_clk_i)
	begin
		if (clear_all)
			flag_seen <= 1'b0;
		else if (rd_tctl && timer_control_status[RMC_B_CMF])
			flag_seen <= 1'b1;
		else if (wr_tctl)
			flag_seen <= 1'b0;
	end

	// Match sets the flag even in the cycle software clears it
	always_ff @(posedge ref_clk_i)
	begin
		if (clear_all)
			timer_control_status <= RMC_TCTL_RST;
		else
		begin
			if (wr_tctl && !mem_on)
				timer_control_status[6:3] <= hwdata_i[6:3];
			if (mem_on)
				timer_control_status[RMC_B_CMIE] <= 1'b0;
			if (compare_match_i)
				timer_control_status[RMC_B_CMF] <= 1'b1;
			else if (wr_tctl && flag_seen && !hwdata_i[RMC_B_CMF])
				timer_control_status[RMC_B_CMF] <= 1'b0;
			timer_control_status[2:0] <= RMC_TCTL_ONES[2:0];
		end
	end

	// Counter and constant are frozen while a memory is connected
	always_ff @(posedge ref_clk_i)
	begin
		if (clear_all)
		begin
			interval_counter <= RMC_TCNT_RST;
			interval_constant <= RMC_TCON_RST;
		end
		else
		begin
			if (wr_tcnt && !mem_on)
				interval_counter <= hwdata_i[7:0];
			if (wr_tcon && !mem_on)
				interval_constant <= hwdata_i[7:0];
		end
	end

	assign timer_clock_select_o = {5'h00, timer_control_status[5:3]};

	// ***********************************************************
	// Software standby and self-refresh
	// ***********************************************************
	always_comb
	begin
		next_sb_state = sb_state;
		unique case (sb_state)
			RMC_SB_NORMAL:
			begin
				if (sw_standby_i && mem_ok
					&& refresh_mode_control[RMC_B_SELF]
					&& !cyc.active)
					next_sb_state = RMC_SB_SELF;
			end
			RMC_SB_SELF:
			begin
				if (!sw_standby_i)
					next_sb_state = RMC_SB_RESUME;
			end
			RMC_SB_RESUME: next_sb_state = RMC_SB_NORMAL;
			default: next_sb_state = RMC_SB_NORMAL;
		endcase
	end

	// Hardware standby also drops any self-refresh in progress
	always_ff @(posedge ref_clk_i)
	begin
		if (clear_all)
			sb_state <= RMC_SB_NORMAL;
		else
			sb_state <= next_sb_state;
	end

	assign self_refresh_o = (sb_state == RMC_SB_SELF);

	// ***********************************************************
	// Refresh cycles
	// ***********************************************************
	// Requests during self-refresh and the resume state are dropped; self-refresh covers them
	assign cyc.start = refresh_req_i && refresh_mode_control[RMC_B_CYC]
		&& mem_ok && (sb_state == RMC_SB_NORMAL) && !cyc.active;

	rmc_cycle u_cycle
	(
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.cyc(cyc)
	);

	assign refresh_cycle_o = cyc.active;

	// Pin owned by refresh logic or by the general port
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			refresh_indicator_pin_o <= 1'b1;
			refresh_indicator_pin_oe_n_o <= 1'b1;
		end
		else if (refresh_mode_control[RMC_B_PIN])
		begin
			refresh_indicator_pin_o <= !(cyc.start
				|| (cyc.active && !cyc.last));
			refresh_indicator_pin_oe_n_o <= 1'b0;
		end
		else
		begin
			refresh_indicator_pin_o <= port_data_i;
			refresh_indicator_pin_oe_n_o <= port_oe_n_i;
		end
	end

	// ***********************************************************
	// Area 3 bus shaping and DRAM options
	// ***********************************************************
	// Options are only meaningful in DRAM mode, so gate them there
	always_ff @(posedge ref_clk_i)
	begin
		if (clear_all)
		begin
			area3_three_state_o <= 1'b0;
			area3_wait_enable_o <= 1'b0;
			dram_mode_o <= 1'b0;
			psram_mode_o <= 1'b0;
			strobe_two_cas_o <= 1'b0;
			column_nine_bit_o <= 1'b0;
		end
		else
		begin
			area3_three_state_o <= mem_on;
			area3_wait_enable_o <= mem_on
				&& area3_access_state_bit_i;
			dram_mode_o <= (mem == RMC_MEM_DRAM);
			psram_mode_o <= (mem == RMC_MEM_PSRAM);
			strobe_two_cas_o <= (mem == RMC_MEM_DRAM)
				&& refresh_mode_control[RMC_B_STROBE];
			column_nine_bit_o <= (mem == RMC_MEM_DRAM)
				&& refresh_mode_control[RMC_B_COL];
		end
	end

	// ***********************************************************
	// Assertions
	// ***********************************************************
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	a_cycle_needs_mode: assert property
		($rose(refresh_cycle_o)
		|-> $past(refresh_mode_control[RMC_B_CYC] && mem_ok))
		else $error("refresh cycle without enable");
	a_pin_low_cycle: assert property
		(refresh_mode_control[RMC_B_PIN] && cyc.start
		&& $stable(refresh_mode_control)
		|=> !refresh_indicator_pin_o [*3])
		else $error("refresh pin not low in cycle");
	a_pin_released: assert property
		(!refresh_mode_control[RMC_B_PIN]
		|=> refresh_indicator_pin_oe_n_o == $past(port_oe_n_i))
		else $error("refresh pin not released");
	a_fixed_bit_one: assert property
		(refresh_mode_control[RMC_B_FIXED])
		else $error("mode bit 1 not one");
	a_locked_fields: assert property
		(mem_on && !hw_standby_i |=> (refresh_mode_control & 8'h1D)
		== ($past(refresh_mode_control) & 8'h1D))
		else $error("locked mode field changed");
	a_locked_const: assert property
		(mem_on && !hw_standby_i |=> $stable(interval_constant))
		else $error("constant written while locked");
	a_hwsb_load: assert property
		(hw_standby_i |=> refresh_mode_control == RMC_MODE_RST)
		else $error("mode not reloaded");
	a_self_enter: assert property
		(sb_state == RMC_SB_NORMAL && sw_standby_i && mem_ok
		&& refresh_mode_control[RMC_B_SELF] && !cyc.active
		&& !hw_standby_i |=> self_refresh_o)
		else $error("self-refresh not entered");
	a_self_exit: assert property
		(self_refresh_o && !sw_standby_i && !hw_standby_i
		|=> ##1 sb_state == RMC_SB_NORMAL)
		else $error("normal access not resumed");
	a_no_waits: assert property
		(mem_on && !area3_access_state_bit_i && !hw_standby_i
		|=> !area3_wait_enable_o && area3_three_state_o)
		else $error("waits allowed in area 3");
	a_strobe_dram: assert property
		(strobe_two_cas_o |-> $past(mem == RMC_MEM_DRAM))
		else $error("strobe style outside DRAM");
	a_column_dram: assert property
		(column_nine_bit_o |-> $past(mem == RMC_MEM_DRAM))
		else $error("column width outside DRAM");
	a_no_illegal: assert property
		(mem == RMC_MEM_BAD |-> !cyc.start && !self_refresh_o)
		else $error("illegal mode acted on");
endmodule

// file: verif/rmc_mem_model.sv
`timescale 1ns/1ps
// ***********************************************************
// Far-side memory in area 3
// ***********************************************************
// Counts refresh pulses seen on the pin and flags any wrong length
module rmc_mem_model
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	input wire logic oe_n_i,
	output logic [7:0] pulses_o,
	output logic bad_o
);
	logic [3:0] low_len;
	// A short pulse would leave rows unrefreshed, so length is checked
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			low_len <= 4'h0;
			pulses_o <= 8'h00;
			bad_o <= 1'b0;
		end
		else if (!oe_n_i && !pin_i)
			low_len <= low_len + 4'h1;
		else
		begin
			if (low_len != 4'h0)
			begin
				pulses_o <= pulses_o + 8'h01;
				bad_o <= bad_o | (low_len != 4'h3);
			end
			low_len <= 4'h0;
		end
	end
endmodule

// file: verif/refresh_mode_control_test.sv
`timescale 1ns/1ps
module refresh_mode_control_test;
	import rmc_pkg::*;
	logic ref_clk_i, rst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
	logic hw_standby_i, sw_standby_i, refresh_req_i, compare_match_i;
	logic area3_access_state_bit_i, port_data_i, port_oe_n_i;
	logic refresh_indicator_pin_o, refresh_indicator_pin_oe_n_o;
	logic area3_three_state_o, area3_wait_enable_o, refresh_cycle_o;
	logic dram_mode_o, psram_mode_o, strobe_two_cas_o, column_nine_bit_o;
	logic self_refresh_o, bad;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i;
	logic [7:0] haddr_i, timer_clock_select_o, pulses;
	logic [31:0] hwdata_i, hrdata_o, rd;
	logic [1:0] order [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
	logic [1:0] en;
	int n_errors = 0;
	int n_checks = 0;
	int n;
	// Single slave, so its ready is the bus ready
	assign hready_i = hreadyout_o;
	// 50 MHz system clock
	always #10 ref_clk_i = ~ref_clk_i;
	rmc_top i_dut (.ref_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o,
		.hrdata_o, .hw_standby_i, .sw_standby_i, .refresh_req_i,
		.compare_match_i, .area3_access_state_bit_i, .port_data_i,
		.port_oe_n_i, .refresh_indicator_pin_o, .refresh_indicator_pin_oe_n_o,
		.area3_three_state_o, .area3_wait_enable_o, .refresh_cycle_o,
		.dram_mode_o, .psram_mode_o, .strobe_two_cas_o, .column_nine_bit_o,
		.self_refresh_o, .timer_clock_select_o);
	rmc_mem_model i_mem (.ref_clk_i, .rst_i, .pin_i(refresh_indicator_pin_o),
		.oe_n_i(refresh_indicator_pin_oe_n_o), .pulses_o(pulses), .bad_o(bad));
	// ***********************************************************
	// Bus and check tasks
	// ***********************************************************
	task summarize;
		if (n_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Bounded wait, so a stuck slave cannot hang the run
	task wait_rdy;
		int k;
		k = 0;
		@(posedge ref_clk_i);
		while (hreadyout_o !== 1'b1)
		begin
			k++;
			if (k > 20)
			begin
				n_errors++;
				summarize;
			end
			@(posedge ref_clk_i);
		end
	endtask
	// One single transfer; read data is taken at the data-phase edge
	task xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		haddr_i <= a;
		hwrite_i <= wr;
		htrans_i <= RMC_HTRANS_NONSEQ;
		wait_rdy;
		htrans_i <= 2'b00;
		hwdata_i <= {24'h000000, d};
		wait_rdy;
		rd = hrdata_o;
		check("hresp", hresp_o, 32'h0);
	endtask
	task rd_chk(input logic [7:0] a, input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		check($sformatf("reg %h", a), rd, {24'h000000, e});
	endtask
	task wait_n(input int c);
		repeat (c) @(negedge ref_clk_i);
	endtask
	// Requests one refresh and counts the cycles it lasts
	task refresh(output int c);
		@(posedge ref_clk_i);
		refresh_req_i <= 1'b1;
		@(posedge ref_clk_i);
		refresh_req_i <= 1'b0;
		c = 0;
		repeat (6)
		begin
			@(negedge ref_clk_i);
			c += (refresh_cycle_o === 1'b1);
		end
	endtask
	// ***********************************************************
	// Main sequence
	// ***********************************************************
	initial
	begin
		ref_clk_i = 1'b0;
		rst_i = 1'b1;
		{hsel_i, hwrite_i, hw_standby_i, sw_standby_i} = 4'h8;
		{refresh_req_i, compare_match_i, area3_access_state_bit_i} = 3'h0;
		{port_data_i, port_oe_n_i} = 2'b11;
		{haddr_i, htrans_i, hsize_i, hwdata_i} = {8'h00, 2'b00, 3'b010, 32'h0};
		repeat (4) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rd_chk(RMC_OFS_MODE, 8'h02);
		rd_chk(RMC_OFS_TCTL, 8'h07);
		rd_chk(RMC_OFS_TCNT, 8'h00);
		rd_chk(RMC_OFS_TCON, 8'hFF);
		rd_chk(8'h14, 8'h00);
		rd_chk(RMC_OFS_STAT, 8'h11);
		xfer(1'b1, RMC_OFS_MODE, 8'h00);
		rd_chk(RMC_OFS_MODE, 8'h02);
		xfer(1'b1, RMC_OFS_TCNT, 8'h55);
		rd_chk(RMC_OFS_TCNT, 8'h55);
		xfer(1'b1, RMC_OFS_TCON, 8'h80);
		rd_chk(RMC_OFS_TCON, 8'h80);
		xfer(1'b1, RMC_OFS_TCTL, 8'h18);
		rd_chk(RMC_OFS_TCTL, 8'h1F);
		wait_n(1);
		check("clksel", timer_clock_select_o, 8'h03);
		// Timer use only: the cycle bit alone inserts nothing
		xfer(1'b1, RMC_OFS_MODE, 8'h05);
		rd_chk(RMC_OFS_MODE, 8'h07);
		refresh(n);
		check("cycles", n, 0);
		check("oe_n", refresh_indicator_pin_oe_n_o, 1'b0);
		check("pin", refresh_indicator_pin_o, 1'b1);
		// Released pin follows the port's enable, then its data
		xfer(1'b1, RMC_OFS_MODE, 8'h00);
		port_oe_n_i <= 1'b0;
		wait_n(3);
		check("port drive", refresh_indicator_pin_oe_n_o, 1'b0);
		@(posedge ref_clk_i);
		port_oe_n_i <= 1'b1;
		port_data_i <= 1'b0;
		wait_n(3);
		check("port", refresh_indicator_pin_o, 1'b0);
		check("port oe_n", refresh_indicator_pin_oe_n_o, 1'b1);
		// DRAM with all lower bits set before the lock closes
		xfer(1'b1, RMC_OFS_MODE, 8'h1D);
		xfer(1'b1, RMC_OFS_MODE, 8'h3D);
		wait_n(2);
		check("three", area3_three_state_o, 1'b1);
		check("waits", area3_wait_enable_o, 1'b0);
		@(posedge ref_clk_i);
		area3_access_state_bit_i <= 1'b1;
		wait_n(3);
		check("waits on", area3_wait_enable_o, 1'b1);
		refresh(n);
		check("cycles", n, 3);
		xfer(1'b1, RMC_OFS_MODE, 8'h20);
		rd_chk(RMC_OFS_MODE, 8'h3F);
		xfer(1'b1, RMC_OFS_TCNT, 8'h00);
		rd_chk(RMC_OFS_TCNT, 8'h55);
		xfer(1'b1, RMC_OFS_TCON, 8'h11);
		rd_chk(RMC_OFS_TCON, 8'h80);
		xfer(1'b1, RMC_OFS_TCTL, 8'h00);
		rd_chk(RMC_OFS_TCTL, 8'h1F);
		// Flag clears by writing 0 once a read has seen it set
		@(posedge ref_clk_i);
		compare_match_i <= 1'b1;
		@(posedge ref_clk_i);
		compare_match_i <= 1'b0;
		rd_chk(RMC_OFS_TCTL, 8'h9F);
		xfer(1'b1, RMC_OFS_TCTL, 8'h1F);
		rd_chk(RMC_OFS_TCTL, 8'h1F);
		// Every memory type, the illegal pair included, with self-refresh on
		for (int i = 0; i < 4; i++)
		begin
			en = order[i];
			xfer(1'b1, RMC_OFS_MODE, {1'b1, en, 5'h00});
			wait_n(2);
			check("dram", dram_mode_o, en == 2'b01);
			check("psram", psram_mode_o, en == 2'b10);
			check("three", area3_three_state_o, en != 2'b00);
			check("cas2", strobe_two_cas_o, en == 2'b01);
			check("col9", column_nine_bit_o, en == 2'b01);
			rd_chk(RMC_OFS_STAT, 8'h10 | (8'h01 << en));
			refresh(n);
			check("cycles", n, (en == 2'b01 || en == 2'b10) ? 3 : 0);
			@(posedge ref_clk_i);
			sw_standby_i <= 1'b1;
			wait_n(2);
			check("self", self_refresh_o, en == 2'b01 || en == 2'b10);
			@(posedge ref_clk_i);
			sw_standby_i <= 1'b0;
			wait_n(3);
			check("resume", self_refresh_o, 1'b0);
			rd_chk(RMC_OFS_STAT, 8'h10 | (8'h01 << en));
		end
		xfer(1'b1, RMC_OFS_MODE, 8'h20);
		@(posedge ref_clk_i);
		hw_standby_i <= 1'b1;
		@(posedge ref_clk_i);
		hw_standby_i <= 1'b0;
		rd_chk(RMC_OFS_MODE, 8'h02);
		check("dram off", dram_mode_o, 1'b0);
		check("pulses", pulses, 8'h03);
		check("length", bad, 1'b0);
		summarize;
	end
endmodule
